// ===== bench/ecl_ee_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecl_ee_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire ecl_pkg::ecl_eereq_s ee_req,
   output logic ee_rvalid,
   output logic [7:0] ee_rdata
);
   import ecl_pkg::*;
   logic [7:0] mem [0:2047];
   logic [10:0] addr_ff;
   logic pend_ff, wait_ff, slow_ff, ans;
   assign ans = aresetn && pend_ff && !wait_ff && !ee_req.rd;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {ee_rvalid, ee_rdata, pend_ff, wait_ff, slow_ff} = '0;
   end
   always @(posedge aclk) begin
      ee_rvalid <= ans;
      // Idle bus toggles so a stale byte never matches
      ee_rdata <= ans ? mem[addr_ff] : ~ee_rdata;
      if (ee_req.wr) mem[ee_req.addr] <= ee_req.wdata;
      if (!aresetn) pend_ff <= 1'b0;
      else if (ee_req.rd) begin
         pend_ff <= 1'b1;
         addr_ff <= ee_req.addr;
         // Alternate prompt and slow answers
         wait_ff <= slow_ff;
         slow_ff <= ~slow_ff;
      end else if (pend_ff && wait_ff) wait_ff <= 1'b0;
      else if (pend_ff) pend_ff <= 1'b0;
   end
endmodule
`default_nettype wire

// ===== bench/eeprom_conditional_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecl_params.svh"
`define CHK(n,e,s) begin compares++; if ((e) !== (s)) begin num_errors++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module eeprom_conditional_loader_tb_top;
   import ecl_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic up_valid = 0, awready, wready, bvalid, arready, rvalid, ee_rvalid, up_ready;
   logic io_update, sysclk_cal;
   logic [15:0] awaddr = 0, araddr = 0, la;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 0, c;
   logic [1:0] strap_pin_low = 0, strap_pin_high = 0, bresp, rresp;
   logic [7:0] up_byte = 0, ee_rdata, ld;
   ecl_eereq_s ee_req;
   ecl_regwr_s regmap_wr;
   int num_errors = 0, compares = 0, nw, nc, ni;
   localparam logic [15:0] A_COND = {`ECL_IDX_COND, 2'b00}, A_SAVE = {`ECL_IDX_SAVE, 2'b00};
   localparam logic [15:0] A_LOAD = {`ECL_IDX_LOAD, 2'b00}, A_STAT = {`ECL_IDX_STAT, 2'b00};
   localparam logic [7:0] PROG [17] = '{8'h00, 8'h00, 8'h10, 8'h5A, 8'h5A, 8'hB2, 8'h00,
      8'h00, 8'h20, 8'h33, 8'h33, 8'h0A, 8'hB1, 8'h80, 8'hB0, 8'h0A, 8'hFF};
   localparam logic [7:0] UPB [4] = '{8'hB0, 8'hB3, 8'h0A, 8'hFE};
   always #50 aclk = ~aclk;
   ecl_loader dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .strap_pin_low, .strap_pin_high, .ee_req, .ee_rvalid, .ee_rdata, .up_valid,
      .up_byte, .up_ready, .regmap_wr, .io_update, .sysclk_cal);
   ecl_ee_model ee (.aclk, .aresetn, .ee_req, .ee_rvalid, .ee_rdata);
   always @(posedge aclk) begin
      if (regmap_wr.en) begin
         nw++;
         la = regmap_wr.addr;
         ld = regmap_wr.data;
      end
      if (sysclk_cal) nc++;
      if (io_update) ni++;
   end
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge aclk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hF, 3'b111};
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", `ECL_RESP_OKAY, bresp)
   endtask
   task rd(input logic [15:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      `CHK("rresp", `ECL_RESP_OKAY, rresp)
      rready <= 1'b0;
   endtask
   task idle;
      do rd(A_STAT); while (d[1:0] !== 2'b00);
   endtask
   task rst(input int i);
      {strap_pin_high, strap_pin_low} <= {2'(i / 3), 2'(i % 3)};
      @(posedge aclk) aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task dl(input logic [3:0] v);
      wr(A_COND, {28'h0, v});
      {nw, nc, ni} = '0;
      wr(A_LOAD, 32'h2);
      idle();
   endtask
   // Counts of data writes, calibrations and updates; p is the strap condition
   function logic [5:0] expect_dl(input logic [3:0] v, input logic [3:0] p);
      logic [3:0] e;
      logic x;
      e = (v != 0) ? v : p;
      x = (e == 0) || (e == 2);
      return {2'(1 + x), 2'(1 + x), 2'(e < 3)};
   endfunction
   task conclude;
      $display("counts: compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h03F7C8A7));
      @(posedge aclk);
      foreach (PROG[i]) ee.mem[i] = PROG[i];
      // Low/low comes last so its power-up download runs to the end
      for (int i = 8; i >= 0; i--) begin
         rst(i);
         {nw, nc, ni} = '0;
         rd(A_STAT);
         `CHK("strap_cond", (i == 4) ? 4'h0 : (i < 4) ? 4'(i + 1) : 4'(i), d[15:12])
      end
      $display("test done: straps");
      idle();
      `CHK("auto_dl", expect_dl(0, 1), {nw[1:0], nc[1:0], ni[1:0]})
      `CHK("first_addr", 16'h0010, la)
      `CHK("first_data", 8'h5A, ld)
      `CHK("complete", 1'b1, d[2])
      $display("test done: auto download");
      for (int k = 0; k < 6; k++) begin
         c = (k == 0) ? 4'h2 : (k == 1) ? 4'h3 : 4'($urandom % 16);
         dl(c);
         `CHK("cond_dl", expect_dl(c, 1), {nw[1:0], nc[1:0], ni[1:0]})
      end
      $display("test done: conditions");
      // open straps and zero override give the null condition
      rst(4);
      dl(4'h0);
      `CHK("null_dl", expect_dl(0, 0), {nw[1:0], nc[1:0], ni[1:0]})
      $display("test done: null condition");
      ee.mem[4] = 8'h00;
      dl(4'h1);
      `CHK("fault", 2'b10, d[3:2])
      $display("test done: checksum");
      wr(A_SAVE, 32'h1);
      // later setup: null code, then new tag
      foreach (UPB[j]) begin
         {up_valid, up_byte} <= {1'b1, UPB[j]};
         do @(posedge aclk); while (up_ready !== 1'b1);
      end
      up_valid <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("upload", {8'hB0, 8'hB3, 8'h0A, 8'hFE}, {ee.mem[0], ee.mem[1], ee.mem[2], ee.mem[3]})
      $display("test done: upload");
      conclude();
   end
   initial begin
      #6000000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire

// ===== src/ecl_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecl_params.svh"
// Function
// - Upload copies condition bytes unchanged
// - Condition and end codes always execute
// - Condition zero executes every instruction
// - Strap pins give conditions 1-8, or 0 when both are open
// - Nonzero override nibble beats strap condition
// - Strap condition captured once after reset
// - B1..CF tag matching condition
// - B0 clears whole tag board
// - With tags, execute only when tagged
// - Untagged: execute every instruction
// - Many tags may stand together
// - 0x80 I/O update, 0x0A calibrate
// - Automatic download after power-up unless both straps are open
// - Store holds 2048 bytes at most
// - Data instruction spans N plus five bytes
// - Data moves value plus one, ascending
// - Checksum mismatch in an executed block faults, else complete
module ecl_loader #(
   parameter int EE_BYTES = `ECL_EE_BYTES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [15:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [1:0] strap_pin_low,
   input wire logic [1:0] strap_pin_high,
   output ecl_pkg::ecl_eereq_s ee_req,
   input wire logic ee_rvalid,
   input wire logic [7:0] ee_rdata,
   input wire logic up_valid,
   input wire logic [7:0] up_byte,
   output logic up_ready,
   output ecl_pkg::ecl_regwr_s regmap_wr,
   output logic io_update,
   output logic sysclk_cal
);
   import ecl_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic ecl_hit(input logic [15:0] a, input logic [13:0] idx);
      return a == {idx, 2'b00};
   endfunction

   // strap encoding, 1 to 8, both open gives 0
   // Unknown code 3 is read as high so the result never passes 8
   function automatic logic [3:0] ecl_strap_cond(input logic [1:0] hi, input logic [1:0] lo);
      logic [3:0] h;
      logic [3:0] l;
      logic [3:0] v;
      h = (hi > `ECL_STRAP_HIGH) ? 4'h2 : {2'b00, hi};
      l = (lo > `ECL_STRAP_HIGH) ? 4'h2 : {2'b00, lo};
      v = 4'((h * 4'h3) + l);
      if (hi == `ECL_STRAP_OPEN && lo == `ECL_STRAP_OPEN) begin
         return 4'h0;
      end
      return (v < 4'h4) ? 4'(v + 4'h1) : v;
   endfunction

   // ----------------------------------------------------------------
   // Register slave state
   // ----------------------------------------------------------------
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
   logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
   logic [15:0] wa_addr_ff, nxt_wa_addr;
   logic [7:0] wd_ff, nxt_wd;
   logic wd_en_ff, nxt_wd_en;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] ovr_ff, nxt_ovr;
   logic save_go, load_go;

   // ----------------------------------------------------------------
   // Engine state
   // ----------------------------------------------------------------
   ecl_state_e state_ff, nxt_state;
   ecl_phase_e phase_ff, nxt_phase;
   logic [11:0] rd_ptr_ff, nxt_rd_ptr, up_ptr_ff, nxt_up_ptr;
   logic [7:0] cnt_ff, nxt_cnt, sum_ff, nxt_sum;
   logic [15:0] tgt_ff, nxt_tgt;
   logic exec_ff, nxt_exec, fault_ff, nxt_fault, done_ff, nxt_done;
   logic ovf_ff, nxt_ovf, strap_done_ff, nxt_strap_done, auto_ff, nxt_auto;
   logic [3:0] pin_initial_condition_ff, nxt_pin_initial_condition;
   ecl_eereq_s ee_req_ff, nxt_ee_req;
   ecl_regwr_s regwr_ff, nxt_regwr;
   logic ioupd_ff, nxt_ioupd, cal_ff, nxt_cal, up_ready_ff, nxt_up_ready;
   logic tag_clr, tag_set;
   logic [4:0] tag_idx;
   logic [31:0] tags;
   logic [3:0] cond;
   logic tag_any, exec_now, opc_take;
   logic [11:0] ee_max;

   assign ee_max = 12'(EE_BYTES);
   assign cond = (ovr_ff[3:0] != 4'h0) ? ovr_ff[3:0] : pin_initial_condition_ff;
   assign tag_any = |tags[31:1];
   assign exec_now = (cond == 4'h0) || !tag_any || tags[cond];
   assign opc_take = state_ff == ECL_WAIT && phase_ff == ECL_PH_OPC && ee_rvalid;

   ecl_tag_board u_tags (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(tag_clr),
      .set(tag_set),
      .set_idx(tag_idx),
      .tags(tags)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got = w_got_ff;
      nxt_wa_addr = wa_addr_ff;
      nxt_wd = wd_ff;
      nxt_wd_en = wd_en_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_arready = arready_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      nxt_ovr = ovr_ff;
      save_go = 1'b0;
      load_go = 1'b0;
      if (awvalid && awready_ff) begin
         nxt_aw_got = 1'b1;
         nxt_wa_addr = awaddr;
      end
      if (wvalid && wready_ff) begin
         nxt_w_got = 1'b1;
         nxt_wd = wdata[7:0];
         nxt_wd_en = wstrb[0];
      end
      if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (aw_got_ff && w_got_ff && !bvalid_ff) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = `ECL_RESP_OKAY;
         if (ecl_hit(wa_addr_ff, `ECL_IDX_COND)) begin
            if (wd_en_ff) begin
               nxt_ovr = wd_ff;
            end
         end else if (ecl_hit(wa_addr_ff, `ECL_IDX_SAVE)) begin
            save_go = wd_en_ff && wd_ff[`ECL_SAVE_GO_BIT];
         end else if (ecl_hit(wa_addr_ff, `ECL_IDX_LOAD)) begin
            load_go = wd_en_ff && wd_ff[`ECL_LOAD_GO_BIT];
         end else if (!ecl_hit(wa_addr_ff, `ECL_IDX_STAT)) begin
            nxt_bresp = `ECL_RESP_SLVERR;
         end
      end
      nxt_awready = !nxt_aw_got && !nxt_bvalid;
      nxt_wready = !nxt_w_got && !nxt_bvalid;
      if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
         nxt_arready = 1'b1;
      end
      if (arvalid && arready_ff) begin
         nxt_arready = 1'b0;
         nxt_rvalid = 1'b1;
         nxt_rresp = `ECL_RESP_OKAY;
         nxt_rdata = 32'h00000000;
         if (ecl_hit(araddr, `ECL_IDX_COND)) begin
            nxt_rdata[7:0] = ovr_ff;
         end else if (ecl_hit(araddr, `ECL_IDX_SAVE)) begin
            nxt_rdata[`ECL_SAVE_GO_BIT] = state_ff == ECL_UPLD;
         end else if (ecl_hit(araddr, `ECL_IDX_LOAD)) begin
            nxt_rdata[`ECL_LOAD_GO_BIT] = state_ff == ECL_FETCH || state_ff == ECL_WAIT;
         end else if (ecl_hit(araddr, `ECL_IDX_STAT)) begin
            nxt_rdata[15:0] = {pin_initial_condition_ff, cond, 3'h0, ovf_ff, fault_ff,
               done_ff, state_ff == ECL_FETCH || state_ff == ECL_WAIT, state_ff == ECL_UPLD};
         end else begin
            nxt_rresp = `ECL_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         wa_addr_ff <= 16'h0000;
         wd_ff <= 8'h00;
         wd_en_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `ECL_RESP_OKAY;
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rresp_ff <= `ECL_RESP_OKAY;
         rdata_ff <= 32'h00000000;
         ovr_ff <= `ECL_COND_RST;
      end else begin
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         wa_addr_ff <= nxt_wa_addr;
         wd_ff <= nxt_wd;
         wd_en_ff <= nxt_wd_en;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         ovr_ff <= nxt_ovr;
      end
   end

   // ----------------------------------------------------------------
   // Download and upload engine
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_up_ptr = up_ptr_ff;
      nxt_cnt = cnt_ff;
      nxt_sum = sum_ff;
      nxt_tgt = tgt_ff;
      nxt_exec = exec_ff;
      nxt_fault = fault_ff;
      nxt_done = done_ff;
      nxt_ovf = ovf_ff;
      nxt_auto = auto_ff;
      nxt_up_ready = up_ready_ff;
      nxt_ee_req = '0;
      nxt_regwr = '0;
      nxt_regwr.addr = regwr_ff.addr;
      nxt_ioupd = 1'b0;
      nxt_cal = 1'b0;
      tag_clr = 1'b0;
      tag_set = 1'b0;
      tag_idx = 5'h00;
      // strap caught once, first cycle after reset
      nxt_strap_done = 1'b1;
      nxt_pin_initial_condition = pin_initial_condition_ff;
      if (!strap_done_ff) begin
         nxt_pin_initial_condition = ecl_strap_cond(strap_pin_high, strap_pin_low);
         // power-up download when strap gives a condition
         nxt_auto = ecl_strap_cond(strap_pin_high, strap_pin_low) != 4'h0;
      end
      case (state_ff)
         ECL_IDLE: begin
            if (auto_ff || load_go) begin
               nxt_auto = 1'b0;
               nxt_rd_ptr = 12'h000;
               nxt_phase = ECL_PH_OPC;
               nxt_fault = 1'b0;
               nxt_done = 1'b0;
               tag_clr = 1'b1;
               nxt_state = ECL_FETCH;
            end else if (save_go) begin
               nxt_ovf = 1'b0;
               nxt_up_ready = 1'b1;
               nxt_state = ECL_UPLD;
            end
         end
         ECL_FETCH: begin
            if (rd_ptr_ff >= ee_max) begin
               nxt_fault = 1'b1;
               nxt_state = ECL_IDLE;
            end else begin
               nxt_ee_req.rd = 1'b1;
               nxt_ee_req.addr = rd_ptr_ff[10:0];
               nxt_rd_ptr = 12'(rd_ptr_ff + 12'h001);
               nxt_state = ECL_WAIT;
            end
         end
         ECL_WAIT: begin
            if (ee_rvalid) begin
               nxt_state = ECL_FETCH;
               case (phase_ff)
                  ECL_PH_OPC: begin
                     // end and condition codes ignore tags
                     if (ee_rdata == `ECL_OP_END) begin
                        nxt_done = !fault_ff;
                        nxt_state = ECL_IDLE;
                     end else if (ee_rdata == `ECL_OP_NULL) begin
                        tag_clr = 1'b1;
                     end else if (ee_rdata > `ECL_OP_NULL && ee_rdata <= `ECL_OP_TAG_HI) begin
                        tag_set = 1'b1;
                        tag_idx = 5'(ee_rdata - `ECL_OP_NULL);
                     end else if (ee_rdata == `ECL_OP_IOUPD) begin
                        nxt_ioupd = exec_now;
                     end else if (ee_rdata == `ECL_OP_CAL) begin
                        nxt_cal = exec_now;
                     // skipped blocks are still walked byte by byte
                     end else if (ee_rdata <= `ECL_OP_DATA_HI) begin
                        nxt_cnt = ee_rdata;
                        nxt_exec = exec_now;
                        nxt_sum = 8'h00;
                        nxt_phase = ECL_PH_AHI;
                     end
                  end
                  ECL_PH_AHI: begin
                     nxt_tgt[15:8] = ee_rdata;
                     nxt_phase = ECL_PH_ALO;
                  end
                  ECL_PH_ALO: begin
                     nxt_tgt[7:0] = ee_rdata;
                     nxt_phase = ECL_PH_DAT;
                  end
                  ECL_PH_DAT: begin
                     // value plus one bytes, address counting up
                     nxt_regwr.en = exec_ff;
                     nxt_regwr.addr = tgt_ff;
                     nxt_regwr.data = ee_rdata;
                     nxt_tgt = 16'(tgt_ff + 16'h0001);
                     nxt_sum = 8'(sum_ff + ee_rdata);
                     nxt_cnt = 8'(cnt_ff - 8'h01);
                     if (cnt_ff == 8'h00) begin
                        nxt_phase = ECL_PH_CSM;
                     end
                  end
                  ECL_PH_CSM: begin
                     if (exec_ff && ee_rdata != sum_ff) begin
                        nxt_fault = 1'b1;
                     end
                     nxt_phase = ECL_PH_OPC;
                  end
                  default: nxt_phase = ECL_PH_OPC;
               endcase
            end
         end
         ECL_UPLD: begin
            if (up_valid && up_ready_ff) begin
               if (up_ptr_ff >= ee_max) begin
                  nxt_ovf = 1'b1;
                  nxt_up_ready = 1'b0;
                  nxt_state = ECL_IDLE;
               end else begin
                  // bytes copied as is, no decoding
                  nxt_ee_req.wr = 1'b1;
                  nxt_ee_req.addr = up_ptr_ff[10:0];
                  nxt_ee_req.wdata = up_byte;
                  // Pause keeps the pointer so the next sequence overwrites it
                  if (up_byte != `ECL_OP_PAUSE) begin
                     nxt_up_ptr = 12'(up_ptr_ff + 12'h001);
                  end
                  if (up_byte == `ECL_OP_PAUSE || up_byte == `ECL_OP_END) begin
                     nxt_up_ready = 1'b0;
                     nxt_state = ECL_IDLE;
                  end
               end
            end
         end
         default: nxt_state = ECL_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ECL_IDLE;
         phase_ff <= ECL_PH_OPC;
         rd_ptr_ff <= 12'h000;
         up_ptr_ff <= 12'h000;
         cnt_ff <= 8'h00;
         sum_ff <= 8'h00;
         tgt_ff <= 16'h0000;
         exec_ff <= 1'b0;
         fault_ff <= 1'b0;
         done_ff <= 1'b0;
         ovf_ff <= 1'b0;
         auto_ff <= 1'b0;
         strap_done_ff <= 1'b0;
         pin_initial_condition_ff <= 4'h0;
         ee_req_ff <= '0;
         regwr_ff <= '0;
         ioupd_ff <= 1'b0;
         cal_ff <= 1'b0;
         up_ready_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         rd_ptr_ff <= nxt_rd_ptr;
         up_ptr_ff <= nxt_up_ptr;
         cnt_ff <= nxt_cnt;
         sum_ff <= nxt_sum;
         tgt_ff <= nxt_tgt;
         exec_ff <= nxt_exec;
         fault_ff <= nxt_fault;
         done_ff <= nxt_done;
         ovf_ff <= nxt_ovf;
         auto_ff <= nxt_auto;
         strap_done_ff <= nxt_strap_done;
         pin_initial_condition_ff <= nxt_pin_initial_condition;
         ee_req_ff <= nxt_ee_req;
         regwr_ff <= nxt_regwr;
         ioupd_ff <= nxt_ioupd;
         cal_ff <= nxt_cal;
         up_ready_ff <= nxt_up_ready;
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rresp = rresp_ff;
   assign rdata = rdata_ff;
   assign ee_req = ee_req_ff;
   assign regmap_wr = regwr_ff;
   assign io_update = ioupd_ff;
   assign sysclk_cal = cal_ff;
   assign up_ready = up_ready_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_dl_start;
      state_ff == ECL_IDLE ##1 state_ff == ECL_FETCH;
   endsequence
   sequence s_bad_sum;
      state_ff == ECL_WAIT && phase_ff == ECL_PH_CSM && ee_rvalid && exec_ff &&
         ee_rdata != sum_ff;
   endsequence

   null_cond_a: assert property (
      opc_take && ee_rdata == `ECL_OP_IOUPD && cond == 4'h0 |=> io_update)
      else $error("update skipped under null condition");
   strap_range_a: assert property (
      strap_done_ff |-> pin_initial_condition_ff <= 4'h8)
      else $error("strap condition above 8");
   override_pick_a: assert property (
      opc_take && ee_rdata == `ECL_OP_CAL && ovr_ff[3:0] != 4'h0 && tag_any &&
         !tags[ovr_ff[3:0]] |=> !sysclk_cal)
      else $error("override condition not used");
   tag_add_a: assert property (
      opc_take && ee_rdata > `ECL_OP_NULL && ee_rdata <= `ECL_OP_TAG_HI |=>
         tags[5'($past(ee_rdata) - `ECL_OP_NULL)] && ((tags & $past(tags)) == $past(tags)))
      else $error("tag not added");
   tag_null_a: assert property (
      opc_take && ee_rdata == `ECL_OP_NULL |=> tags == 32'h00000000)
      else $error("null did not clear tags");
   skip_data_a: assert property (
      state_ff == ECL_WAIT && phase_ff == ECL_PH_DAT && ee_rvalid && !exec_ff |=>
         !regmap_wr.en)
      else $error("skipped block wrote register");
   end_exec_a: assert property (
      opc_take && ee_rdata == `ECL_OP_END |=> state_ff == ECL_IDLE && done_ff == !$past(fault_ff))
      else $error("end code not executed");
   auto_load_a: assert property (
      $rose(strap_done_ff) && pin_initial_condition_ff != 4'h0 |=> state_ff == ECL_FETCH)
      else $error("no power-up download");
   capacity_a: assert property (
      ee_req.wr |-> $past(up_ptr_ff) < 12'(EE_BYTES))
      else $error("write beyond store");
   sum_fault_a: assert property (
      s_bad_sum |=> fault_ff ##1 1'b1)
      else $error("checksum mismatch missed");
   tag_fresh_a: assert property (
      s_dl_start |-> tags == 32'h00000000)
      else $error("tags kept across download");
   copy_raw_a: assert property (
      state_ff == ECL_UPLD && up_valid && up_ready && up_ptr_ff < 12'(EE_BYTES) |=>
         ee_req.wr && ee_req.wdata == $past(up_byte))
      else $error("upload byte altered");

endmodule
`default_nettype wire

// ===== src/ecl_params.svh
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ECL_IDX_COND 14'h0E01
`define ECL_IDX_SAVE 14'h0E02
`define ECL_IDX_LOAD 14'h0E03
`define ECL_IDX_STAT 14'h0E04

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ECL_SAVE_GO_BIT 0
`define ECL_LOAD_GO_BIT 1
`define ECL_COND_RST 8'h00
`define ECL_EE_BYTES 2048

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define ECL_OP_DATA_HI 8'h7F
`define ECL_OP_CAL 8'h0A
`define ECL_OP_IOUPD 8'h80
`define ECL_OP_NULL 8'hB0
`define ECL_OP_TAG_HI 8'hCF
`define ECL_OP_PAUSE 8'hFE
`define ECL_OP_END 8'hFF

// ----------------------------------------------------------------
// Strap levels and bus answers
// ----------------------------------------------------------------
`define ECL_STRAP_LOW 2'h0
`define ECL_STRAP_OPEN 2'h1
`define ECL_STRAP_HIGH 2'h2
`define ECL_RESP_OKAY 2'h0
`define ECL_RESP_SLVERR 2'h2

`endif

// ===== src/ecl_pkg.sv
package ecl_pkg;

   typedef enum logic [3:0] {
      ECL_IDLE = 4'h1,
      ECL_FETCH = 4'h2,
      ECL_WAIT = 4'h4,
      ECL_UPLD = 4'h8
   } ecl_state_e;

   typedef enum logic [4:0] {
      ECL_PH_OPC = 5'h01,
      ECL_PH_AHI = 5'h02,
      ECL_PH_ALO = 5'h04,
      ECL_PH_DAT = 5'h08,
      ECL_PH_CSM = 5'h10
   } ecl_phase_e;

   typedef struct packed {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } ecl_regwr_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [10:0] addr;
      logic [7:0] wdata;
   } ecl_eereq_s;

endpackage

// ===== src/ecl_tag_board.sv
`timescale 1ns/1ps
`default_nettype none

module ecl_tag_board (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clr,
   input wire logic set,
   input wire logic [4:0] set_idx,
   output logic [31:0] tags
);
   import ecl_pkg::*;

   logic [31:0] tags_ff;
   logic [31:0] nxt_tags;

   always_comb begin
      nxt_tags = tags_ff;
      if (clr) begin
         nxt_tags = 32'h00000000;
      end
      if (set) begin
         nxt_tags[set_idx] = 1'b1;
      end
      nxt_tags[0] = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tags_ff <= 32'h00000000;
      end else begin
         tags_ff <= nxt_tags;
      end
   end

   assign tags = tags_ff;

endmodule
`default_nettype wire
